// [verilog/buzzer_pkg.sv]
// constants shared by the buzzer tone and envelope generator
`default_nettype none
package buzzer_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 10;
  // register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_GATE = 10'h2EC;
  localparam logic [IDX_W-1:0] IDX_TONE = 10'h2F6;
  localparam logic [IDX_W-1:0] IDX_ENV  = 10'h2F7;
  // field positions
  localparam int GATE_TRUE_BIT = 0;
  localparam int GATE_INV_BIT  = 3;
  localparam int RESTART_BIT   = 0;
  localparam int SEL_LSB       = 1;
  localparam int SEL_MSB       = 3;
  localparam int ENV_RATE_BIT  = 2;
  localparam int ENV_EN_BIT    = 3;
  // reset values
  localparam logic [2:0] SEL_RST  = 3'h0;
  localparam logic       ENV_RST  = 1'h0;
  localparam logic       RATE_RST = 1'h0;
  localparam logic       GATE_RST = 1'h0;
  // tone shaping: base period and top high time in counts
  localparam int         LVL_W       = 3;
  localparam logic [2:0] LVL_MAX     = 3'h0;
  localparam logic [2:0] LVL_MIN     = 3'h7;
  localparam int         TCNT_W      = 5;
  localparam logic [4:0] PER_16      = 5'h10;
  localparam logic [4:0] PER_20      = 5'h14;
  localparam logic [4:0] PER_24      = 5'h18;
  localparam logic [4:0] PER_28      = 5'h1C;
  localparam logic [4:0] HIGH_NARROW = 5'h08;
  localparam logic [4:0] HIGH_WIDE   = 5'h0C;
  // envelope step times
  localparam int CLK_PERIOD_NS    = 40;
  localparam int STEP_FAST_NS     = 62_500_000;
  localparam int STEP_SLOW_NS     = 125_000_000;
  localparam int STEP_FAST_CYCLES = STEP_FAST_NS / CLK_PERIOD_NS;
  localparam int STEP_SLOW_CYCLES = STEP_SLOW_NS / CLK_PERIOD_NS;
  localparam int TIMER_W          = 22;
endpackage : buzzer_pkg
`default_nettype wire

// [verilog/sound_if.sv]
// signals shared between the register side, envelope and divider
`timescale 1ns/1ps
`default_nettype none
interface sound_if;
  logic [2:0] tone_sel;
  logic [2:0] level;
  logic       osc_rise;
  logic       osc_fall;
  logic       tone_active;
  logic       env_en;
  logic       rate_sel;
  logic       restart;
  logic       tone;
  modport ctrl (output tone_sel, osc_rise, osc_fall, tone_active,
                output env_en, rate_sel, restart,
                input level, tone);
  modport env  (input tone_active, env_en, rate_sel, restart,
                output level);
  modport div  (input tone_sel, level, osc_rise, osc_fall,
                input tone_active, output tone);
endinterface : sound_if
`default_nettype wire

// [verilog/tone_divider.sv]
// tone divider with duty ratio taken from the envelope level
`timescale 1ns/1ps
`default_nettype none
module tone_divider (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // shared signals
  sound_if.div     bus
);
  import buzzer_pkg::*;

  logic [TCNT_W-1:0] cnt_reg;
  logic              tone_reg;
  logic [TCNT_W-1:0] period;
  logic [TCNT_W-1:0] high;
  logic              tick;

  // ratios 8..14 count both oscillator edges, so half the period
  // with the same high counts keeps each duty fraction
  always_comb begin
    unique case (bus.tone_sel[1:0])
      2'h0: period = PER_16;
      2'h1: period = PER_20;
      2'h2: period = PER_24;
      default: period = PER_28;
    endcase
    high = (bus.tone_sel[1] ? HIGH_WIDE : HIGH_NARROW)
           - {2'h0, bus.level};
    tick = bus.osc_rise | (bus.osc_fall & ~bus.tone_sel[2]);
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
    end else if (!bus.tone_active) begin
      cnt_reg <= '0;
    end else if (tick) begin
      cnt_reg <= (cnt_reg == period - 5'h01) ? '0 : cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tone_reg <= 1'b0;
    end else begin
      tone_reg <= bus.tone_active && (cnt_reg < high);
    end
  end

  assign bus.tone = tone_reg;
endmodule : tone_divider
`default_nettype wire

// [verilog/envelope_stepper.sv]
// stepped duty-level envelope with selectable step time
`timescale 1ns/1ps
`default_nettype none
module envelope_stepper #(
  parameter int FAST_CYCLES = buzzer_pkg::STEP_FAST_CYCLES,
  parameter int SLOW_CYCLES = buzzer_pkg::STEP_SLOW_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // shared signals
  sound_if.env     bus
);
  import buzzer_pkg::*;

  logic [TIMER_W-1:0] tmr_reg;
  logic [LVL_W-1:0]   lvl_reg;
  logic               act_d_reg;
  logic [TIMER_W-1:0] last;
  logic               clear;
  logic               step_end;

  always_comb begin
    last = bus.rate_sel ? TIMER_W'(SLOW_CYCLES - 1)
                        : TIMER_W'(FAST_CYCLES - 1);
    // a fresh tone, a restart or envelope off returns to full duty
    clear = ~bus.env_en | (bus.tone_active & ~act_d_reg)
            | bus.restart;
    // at or past the end, so a switch to the fast rate mid-step
    // cannot leave the timer running round its whole range
    step_end = (tmr_reg >= last);
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act_d_reg <= 1'b0;
    end else begin
      act_d_reg <= bus.tone_active;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tmr_reg <= '0;
    end else if (clear || step_end) begin
      tmr_reg <= '0;
    end else begin
      tmr_reg <= tmr_reg + 22'h000001;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lvl_reg <= LVL_MAX;
    end else if (clear) begin
      lvl_reg <= LVL_MAX;
    end else if (step_end && lvl_reg != LVL_MIN) begin
      lvl_reg <= lvl_reg + 3'h1;
    end
  end

  assign bus.level = lvl_reg;
endmodule : envelope_stepper
`default_nettype wire

// [verilog/buzzer_tone_envelope_gen.sv]
// buzzer tone generator with envelope, apb registers and pin gating
//
// Notes on behaviour
// - tone select in bits 3:1, restart bit 0; envelope bits 3,2 elsewhere
// - select codes 0..7 divide oscillator by 8,10,12,14,16,20,24,28
// - reset sets tone select to zero, dividing by eight
// - writing one to restart returns duty to maximum; reads zero
// - restart ignored while envelope off or no tone output
// - envelope enable applies stepped duty; off keeps maximum; readable
// - reset clears envelope enable
// - rate select one gives 125 ms steps, zero 62.5 ms; readable
// - full decay is seven steps: 875 ms slow, 437.5 ms fast
// - reset clears rate select, choosing fast steps
// - gate bit one passes tone to pin, zero drives low; readable
// - independent gating: bit 0 gates true pin, bit 3 inverted pin
// - shared gating: bit 0 gates both, bit 3 is plain storage
// - reset clears both gate bits, both pins low
// - inverted pin carries the logical inverse of the true tone
// - eight duty levels: high 8..1 or 12..5 counts per ratio
// - duty returns to maximum when tone output starts
// - independent or shared gating is a build-time choice
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module buzzer_tone_envelope_gen #(
  parameter bit SHARED_GATING    = 1'b0,
  parameter int FAST_STEP_CYCLES = buzzer_pkg::STEP_FAST_CYCLES,
  parameter int SLOW_STEP_CYCLES = buzzer_pkg::STEP_SLOW_CYCLES
) (
  // clock and reset
  input  wire logic                          i_clock,
  input  wire logic                          i_rst_n,
  // apb slave
  input  wire logic                          i_psel,
  input  wire logic                          i_penable,
  input  wire logic                          i_pwrite,
  input  wire logic [buzzer_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [buzzer_pkg::DATA_W-1:0] i_pwdata,
  output logic                               o_pready,
  output logic      [buzzer_pkg::DATA_W-1:0] o_prdata,
  output logic                               o_pslverr,
  // low-speed oscillator clock pin
  input  wire logic                          i_low_speed_osc_clock,
  // buzzer pins
  output logic                               o_tone_out_true,
  output logic                               o_tone_out_inv
);
  import buzzer_pkg::*;

  sound_if snd ();

  // register state
  logic [2:0]        tone_sel_reg;
  logic              env_en_reg;
  logic              rate_sel_reg;
  logic              gate_true_reg;
  logic              gate_inv_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic              true_out_reg;
  logic              inv_out_reg;

  // oscillator synchroniser
  logic              osc_s1_reg;
  logic              osc_s2_reg;
  logic              osc_s3_reg;
  logic              osc_lvl_reg;
  logic              osc_agree;

  // bus decode
  logic [IDX_W-1:0]  idx;
  logic              aligned;
  logic              hit_gate;
  logic              hit_tone;
  logic              hit_env;
  logic              mapped;
  logic              setup;
  logic              access;
  logic              wr_en;
  logic [DATA_W-1:0] rd_data;

  // gating
  logic              tone_active;
  logic              true_gate;
  logic              inv_gate;

  always_comb begin
    idx      = i_paddr[ADDR_W-1:2];
    aligned  = (i_paddr[1:0] == 2'h0);
    hit_gate = aligned && (idx == IDX_GATE);
    hit_tone = aligned && (idx == IDX_TONE);
    hit_env  = aligned && (idx == IDX_ENV);
    mapped   = hit_gate | hit_tone | hit_env;
    setup    = i_psel & ~i_penable;
    access   = i_psel & i_penable;
    wr_en    = access & i_pwrite;
  end

  // zero wait states; unmapped or misaligned access answers with an error
  assign o_pready  = 1'b1;
  assign o_pslverr = access & ~mapped;
  assign o_prdata  = prdata_reg;

  // read data is captured in the setup cycle so the access phase sees
  // a flop output; unused bits and the restart strobe read as zero
  always_comb begin
    rd_data = '0;
    if (hit_gate) begin
      rd_data[GATE_TRUE_BIT] = gate_true_reg;
      rd_data[GATE_INV_BIT]  = gate_inv_reg;
    end
    if (hit_tone) begin
      rd_data[SEL_MSB:SEL_LSB] = tone_sel_reg;
      rd_data[RESTART_BIT]     = 1'b0;
    end
    if (hit_env) begin
      rd_data[ENV_EN_BIT]   = env_en_reg;
      rd_data[ENV_RATE_BIT] = rate_sel_reg;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata_reg <= '0;
    end else if (setup && !i_pwrite) begin
      prdata_reg <= rd_data;
    end
  end

  // tone select
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tone_sel_reg <= SEL_RST;
    end else if (wr_en && hit_tone) begin
      tone_sel_reg <= i_pwdata[SEL_MSB:SEL_LSB];
    end
  end

  // envelope control
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      env_en_reg   <= ENV_RST;
      rate_sel_reg <= RATE_RST;
    end else if (wr_en && hit_env) begin
      env_en_reg   <= i_pwdata[ENV_EN_BIT];
      rate_sel_reg <= i_pwdata[ENV_RATE_BIT];
    end
  end

  // output gate data; bit 3 is kept even when it gates nothing
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gate_true_reg <= GATE_RST;
      gate_inv_reg  <= GATE_RST;
    end else if (wr_en && hit_gate) begin
      gate_true_reg <= i_pwdata[GATE_TRUE_BIT];
      gate_inv_reg  <= i_pwdata[GATE_INV_BIT];
    end
  end

  // three-stage synchroniser; the level moves only when the last two
  // stages agree, which also filters a single-cycle glitch
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
    end else begin
      osc_s1_reg <= i_low_speed_osc_clock;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end

  assign osc_agree = (osc_s2_reg == osc_s3_reg);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_lvl_reg <= 1'b0;
    end else if (osc_agree) begin
      osc_lvl_reg <= osc_s3_reg;
    end
  end

  // gating arrangement fixed at build time
  always_comb begin
    true_gate   = gate_true_reg;
    inv_gate    = SHARED_GATING ? gate_true_reg
                                : gate_inv_reg;
    tone_active = true_gate | inv_gate;
  end

  // hand-off to the envelope and divider
  assign snd.tone_sel    = tone_sel_reg;
  assign snd.osc_rise    = osc_agree & osc_s3_reg & ~osc_lvl_reg;
  assign snd.osc_fall    = osc_agree & ~osc_s3_reg & osc_lvl_reg;
  assign snd.tone_active = tone_active;
  assign snd.env_en      = env_en_reg;
  assign snd.rate_sel    = rate_sel_reg;
  // restart only counts with envelope on and a tone playing
  assign snd.restart     = wr_en & hit_tone & i_pwdata[RESTART_BIT]
                           & env_en_reg & tone_active;

  envelope_stepper #(
    .FAST_CYCLES (FAST_STEP_CYCLES),
    .SLOW_CYCLES (SLOW_STEP_CYCLES)
  ) u_env (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .bus     (snd.env)
  );

  tone_divider u_div (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .bus     (snd.div)
  );

  // pin drivers: a closed gate holds the pin low, never high;
  // changing a gate mid-cycle can clip a pulse
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      true_out_reg <= 1'b0;
      inv_out_reg  <= 1'b0;
    end else begin
      true_out_reg <= true_gate & snd.tone;
      inv_out_reg  <= inv_gate & ~snd.tone;
    end
  end

  assign o_tone_out_true = true_out_reg;
  assign o_tone_out_inv  = inv_out_reg;

  // checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  a_true_gate_low: assert property (
    !$past(true_gate) |-> !o_tone_out_true)
    else $error("true pin high with its gate closed");

  a_inv_gate_low: assert property (
    !$past(inv_gate) |-> !o_tone_out_inv)
    else $error("inverted pin high with its gate closed");

  a_pins_inverse: assert property (
    $past(true_gate) && $past(inv_gate)
    |-> (o_tone_out_inv == !o_tone_out_true))
    else $error("inverted pin is not the inverse of the true pin");

  a_shared_bit3: assert property (
    SHARED_GATING && !gate_true_reg && gate_inv_reg
    |=> !o_tone_out_inv)
    else $error("bit 3 drives the inverted pin under shared gating");

  a_sel_written: assert property (
    wr_en && hit_tone
    |=> tone_sel_reg == $past(i_pwdata[SEL_MSB:SEL_LSB]))
    else $error("tone select not taken from the write");

  a_env_written: assert property (
    wr_en && hit_env
    |=> env_en_reg == $past(i_pwdata[ENV_EN_BIT])
        && rate_sel_reg == $past(i_pwdata[ENV_RATE_BIT]))
    else $error("envelope control not taken from the write");

  a_restart_reads: assert property (
    setup && !i_pwrite && hit_tone
    ##1 access |-> o_prdata[RESTART_BIT] == 1'b0)
    else $error("restart strobe reads as one");

  a_read_returns: assert property (
    setup && !i_pwrite && hit_env ##1 access
    |-> o_prdata[ENV_EN_BIT] == env_en_reg
        && o_prdata[ENV_RATE_BIT] == rate_sel_reg)
    else $error("envelope control reads wrong");

  a_restart_max: assert property (
    snd.restart |=> snd.level == LVL_MAX)
    else $error("restart did not return duty to maximum");

  a_restart_ignored: assert property (
    wr_en && hit_tone && i_pwdata[RESTART_BIT] && !env_en_reg
    |-> !snd.restart)
    else $error("restart accepted while envelope off");

  a_env_off_max: assert property (
    !env_en_reg |=> snd.level == LVL_MAX)
    else $error("duty not at maximum with envelope off");

  a_tone_start_max: assert property (
    !tone_active ##1 tone_active |=> snd.level == LVL_MAX)
    else $error("duty not at maximum when tone starts");

  a_min_hold: assert property (
    snd.level == LVL_MIN && env_en_reg && tone_active
    && $past(tone_active) && !snd.restart
    |=> snd.level == LVL_MIN)
    else $error("minimum duty level not held");

  a_level_step: assert property (
    $changed(snd.level) && snd.level != LVL_MAX
    |-> snd.level == $past(snd.level) + 3'h1)
    else $error("envelope skipped a duty level");

  a_unmapped_err: assert property (
    access && !mapped |-> o_pslverr && o_pready)
    else $error("unmapped access not refused");

  a_gate_written: assert property (
    wr_en && hit_gate
    |=> gate_true_reg == $past(i_pwdata[GATE_TRUE_BIT])
        && gate_inv_reg == $past(i_pwdata[GATE_INV_BIT]))
    else $error("gate bits not taken from the write");

  // a refused write must leave every control bit alone
  a_refused_write: assert property (
    wr_en && !mapped
    |=> $stable(tone_sel_reg) && $stable(env_en_reg)
        && $stable(rate_sel_reg) && $stable(gate_true_reg)
        && $stable(gate_inv_reg))
    else $error("refused write changed a register");

  a_true_follows: assert property (
    $past(true_gate) |-> o_tone_out_true == $past(snd.tone))
    else $error("open true gate does not pass the tone");

  a_inv_follows: assert property (
    $past(inv_gate) |-> o_tone_out_inv == !$past(snd.tone))
    else $error("open inverted gate does not pass the inverse");

  a_idle_tone_low: assert property (
    !tone_active |=> !snd.tone)
    else $error("tone runs with both gates closed");

  c_restart: cover property (snd.restart);
  c_min_level: cover property (
    snd.level == LVL_MIN && tone_active);
  c_both_pins: cover property (
    o_tone_out_true ##1 o_tone_out_inv);
  c_fast_step: cover property (
    env_en_reg && !rate_sel_reg && $changed(snd.level));
  c_slow_step: cover property (
    env_en_reg && rate_sel_reg && $changed(snd.level));
endmodule : buzzer_tone_envelope_gen
`default_nettype wire

// [verification/buzzer_partner.sv]
// piezo buzzer model: measures the tone seen on the true pin, flags overlap of the two pins
`timescale 1ns/1ps
`default_nettype none
module buzzer_partner (
  // clock
  input  wire logic        i_clock,
  // buzzer pins
  input  wire logic        i_tone_true,
  input  wire logic        i_tone_inv,
  // last measured waveform, in clocks
  output logic      [31:0] o_high,
  output logic      [31:0] o_period,
  output logic             o_overlap
);
  logic [31:0] count_reg;
  logic        last_reg;

  initial begin
    count_reg = 32'h00000000;
    last_reg  = 1'b0;
    o_high    = 32'h00000000;
    o_period  = 32'h00000000;
    o_overlap = 1'b0;
  end

  // a piezo between the pins sees a short if both pins are high together
  always @(posedge i_clock) begin
    count_reg <= count_reg + 32'h00000001;
    last_reg  <= i_tone_true;
    if (i_tone_true && i_tone_inv)
      o_overlap <= 1'b1;
    if (i_tone_true && !last_reg) begin
      o_period  <= count_reg;
      count_reg <= 32'h00000001;
    end
    if (!i_tone_true && last_reg)
      o_high <= count_reg;
  end
endmodule : buzzer_partner
`default_nettype wire

// [verification/buzzer_tone_envelope_gen_test.sv]
// self-checking bench for the buzzer tone and envelope generator
`timescale 1ns/1ps
`default_nettype none
module buzzer_tone_envelope_gen_test;
  import buzzer_pkg::*;
  localparam int FAST = 400;
  localparam int SLOW = 800;
  localparam int OSC_HALF = 5;
  localparam logic [ADDR_W-1:0] A_GATE = {IDX_GATE, 2'b00};
  localparam logic [ADDR_W-1:0] A_TONE = {IDX_TONE, 2'b00};
  localparam logic [ADDR_W-1:0] A_ENV  = {IDX_ENV, 2'b00};

  logic              clock, rst_n, psel, penable, pwrite, osc;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic              pready, pslverr, tt, ti, st, si, overlap;
  logic [31:0]       p_high, p_period;
  int                bad_count, tests_run, cycles;

  buzzer_tone_envelope_gen #(.SHARED_GATING(1'b0),
    .FAST_STEP_CYCLES(FAST), .SLOW_STEP_CYCLES(SLOW)) dut (
    .i_clock(clock), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_low_speed_osc_clock(osc),
    .o_tone_out_true(tt), .o_tone_out_inv(ti));

  // second build with shared gating sees the same register traffic
  buzzer_tone_envelope_gen #(.SHARED_GATING(1'b1),
    .FAST_STEP_CYCLES(FAST), .SLOW_STEP_CYCLES(SLOW)) dut_shared (
    .i_clock(clock), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(), .o_prdata(), .o_pslverr(),
    .i_low_speed_osc_clock(osc),
    .o_tone_out_true(st), .o_tone_out_inv(si));

  buzzer_partner piezo (.i_clock(clock), .i_tone_true(tt),
    .i_tone_inv(ti), .o_high(p_high), .o_period(p_period),
    .o_overlap(overlap));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // oscillator edges stay well apart so the synchroniser sees each one
  initial begin
    osc = 1'b0;
    forever begin
      repeat (OSC_HALF) @(posedge clock);
      osc <= ~osc;
    end
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; an idle cycle in front keeps drivers single-valued
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr,
                     input logic [DATA_W-1:0] data,
                     output logic [DATA_W-1:0] rd, output logic err);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] addr, input logic [3:0] v);
    logic [DATA_W-1:0] rd;
    logic              err;
    apb(1'b1, addr, {28'h0000000, v}, rd, err);
  endtask : wr

  task automatic rdchk(input logic [ADDR_W-1:0] addr,
                       input logic [DATA_W-1:0] exp, input logic exp_err);
    logic [DATA_W-1:0] rd;
    logic              err;
    apb(1'b0, addr, 32'h00000000, rd, err);
    check(rd, exp);
    check({31'h00000000, err}, {31'h00000000, exp_err});
  endtask : rdchk

  task automatic t_reset();
    check({28'h0000000, tt, ti, st, si}, 32'h00000000);
    rdchk(A_TONE, 32'h00000000, 1'b0);
    rdchk(A_ENV, 32'h00000000, 1'b0);
    rdchk(A_GATE, 32'h00000000, 1'b0);
  endtask : t_reset

  task automatic t_regs();
    wr(A_ENV, 4'hF);
    rdchk(A_ENV, 32'h0000000C, 1'b0);
    wr(A_TONE, 4'hF);
    rdchk(A_TONE, 32'h0000000E, 1'b0);
    wr(A_GATE, 4'hF);
    rdchk(A_GATE, 32'h00000009, 1'b0);
    wr(A_GATE + 12'h002, 4'h0);
    rdchk(A_GATE, 32'h00000009, 1'b0);
    rdchk(12'h004, 32'h00000000, 1'b1);
    rdchk(A_GATE + 12'h001, 32'h00000000, 1'b1);
    wr(A_ENV, 4'h0);
    wr(A_GATE, 4'h0);
  endtask : t_regs

  task automatic t_freq();
    int ratio [8] = '{8, 10, 12, 14, 16, 20, 24, 28};
    logic [2:0] s;
    wr(A_GATE, 4'h9);
    for (int k = 0; k < 8; k++) begin
      s = k[2:0];
      wr(A_TONE, {s, 1'b0});
      repeat (900) @(posedge clock);
      check(p_period, ratio[k] * 2 * OSC_HALF);
      check(p_high, (s[1] ? 12 : 8) * (s[2] ? 2 : 1) * OSC_HALF);
    end
  endtask : t_freq

  task automatic t_env();
    wr(A_TONE, 4'h8);
    wr(A_ENV, 4'h8);
    wr(A_TONE, 4'h9);
    repeat (2700) @(posedge clock);
    check(p_high, 32'h00000014);
    repeat (500) @(posedge clock);
    check(p_high, 32'h0000000A);
    repeat (1000) @(posedge clock);
    check(p_high, 32'h0000000A);
    wr(A_TONE, 4'h9);
    repeat (330) @(posedge clock);
    check(p_high, 32'h00000050);
    wr(A_ENV, 4'hC);
    wr(A_TONE, 4'h9);
    repeat (700) @(posedge clock);
    check(p_high, 32'h00000050);
    repeat (500) @(posedge clock);
    check(p_high, 32'h00000046);
    wr(A_ENV, 4'h0);
    repeat (330) @(posedge clock);
    check(p_high, 32'h00000050);
  endtask : t_env

  task automatic t_gate();
    logic [3:0] vals [4] = '{4'h1, 4'h8, 4'h0, 4'h9};
    logic [3:0] act, v;
    wr(A_TONE, 4'h0);
    for (int k = 0; k < 4; k++) begin
      v = vals[k];
      wr(A_GATE, v);
      repeat (100) @(posedge clock);
      act = 4'h0;
      repeat (300) begin
        @(posedge clock);
        act = act | {si, st, ti, tt};
      end
      check({30'h00000000, act[1:0]}, {30'h00000000, v[3], v[0]});
      check({30'h00000000, act[3:2]}, {30'h00000000, v[0], v[0]});
    end
  endtask : t_gate

  initial begin
    bad_count = 0;
    tests_run = 0;
    cycles    = 0;
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_regs();
    t_freq();
    t_env();
    t_gate();
    check({31'h0, overlap}, 32'h00000000);
    test_done();
  end
endmodule : buzzer_tone_envelope_gen_test
`default_nettype wire
